// *** imsw_pkg.sv ***
// package of constants and types for the interface mode select and flush/wake block
package imsw_pkg;
	// ****************************************************************
	// base modes read from configuration memory and active modes
	// ****************************************************************
	typedef enum logic [2:0] {
		IMSW_BASE_UART,
		IMSW_BASE_ASYNC_FIFO,
		IMSW_BASE_CPU_FIFO,
		IMSW_BASE_HDBUS,
		IMSW_BASE_FAST_SERIAL
	} imsw_base_t;

	typedef enum logic [3:0] {
		IMSW_ACT_UART,
		IMSW_ACT_ASYNC_FIFO,
		IMSW_ACT_SYNC_FIFO,
		IMSW_ACT_CPU_FIFO,
		IMSW_ACT_HDBUS,
		IMSW_ACT_FAST_SERIAL,
		IMSW_ACT_ASYNC_BB,
		IMSW_ACT_SYNC_BB,
		IMSW_ACT_SERIAL_ENGINE
	} imsw_act_t;

	// ****************************************************************
	// host bit-mode command values
	// ****************************************************************
	localparam logic [7:0] BM_RESET      = 8'h00;
	localparam logic [7:0] BM_ASYNC_BB   = 8'h01;
	localparam logic [7:0] BM_SERIAL_ENG = 8'h02;
	localparam logic [7:0] BM_SYNC_BB    = 8'h04;
	localparam logic [7:0] BM_FS_HOLD    = 8'h10;
	localparam logic [7:0] BM_SYNC_FIFO  = 8'h40;

	// ****************************************************************
	// configuration word layout (one word from external memory)
	// ****************************************************************
	localparam int CFG_W          = 16;
	localparam int CFG_MODE_LSB   = 0;  // 3 bits, imsw_base_t code
	localparam int CFG_DRIVE_LSB  = 4;  // 2 bits drive strength
	localparam int CFG_SLEW_BIT   = 6;
	localparam int CFG_SCHMITT_BIT = 7;
	localparam int CFG_PULLDN_BIT = 8;

	// ****************************************************************
	// AHB-Lite register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] REG_CMD    = 8'h00;  // w: bit-mode value, r: last value
	localparam logic [7:0] REG_STATUS = 8'h04;  // r: mode, flush, wake, fs reset
	localparam logic [7:0] REG_CFG    = 8'h08;  // r: configuration word
	localparam logic [7:0] REG_CTRL   = 8'h0C;  // rw: bit0 enumerated, bit1 suspended
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int  CLK_HZ        = 50_000_000;
	localparam int  FLUSH_NS      = 250;        // short pulse for send immediate
	localparam int  WAKE_MS       = 20;         // long pulse for remote wake
	localparam int  FLUSH_CYC     = (FLUSH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int  WAKE_CYC      = WAKE_MS * (CLK_HZ / 1000);
	localparam int  CFG_LOAD_CYC  = 4;          // read latency of the config word
endpackage

// *** imsw_cfg_if.sv ***
// interface carrying configuration-memory read signals
`timescale 1ns/1ps
interface imsw_cfg_if #(parameter int W = 16);
	logic         req;
	logic         done;
	logic [W-1:0] word;
	modport ctl (output req, input done, input word);
	modport ldr (input req, output done, output word);
endinterface

// *** imsw_cfg_loader.sv ***
// loader that fetches the configuration word after reset
`timescale 1ns/1ps
module imsw_cfg_loader #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// external configuration memory
	input  wire logic [W-1:0] mem_word,
	// to the controller
	imsw_cfg_if.ldr           cfg
);
	logic [2:0]   cnt_r, cnt_nxt;
	logic         done_r, done_nxt;
	logic [W-1:0] word_r, word_nxt;

	// wait the memory latency then capture once; reset reloads
	always_comb begin
		cnt_nxt  = cnt_r;
		done_nxt = done_r;
		word_nxt = word_r;
		if (cfg.req && !done_r) begin
			if (cnt_r == 3'(imsw_pkg::CFG_LOAD_CYC - 1)) begin
				done_nxt = 1'b1;
				word_nxt = mem_word;
			end else begin
				cnt_nxt = cnt_r + 3'd1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r  <= '0;
			done_r <= 1'b0;
			word_r <= '0;
		end else begin
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
			word_r <= word_nxt;
		end
	end

	assign cfg.done = done_r;
	assign cfg.word = word_r;
endmodule

// *** imsw_pulse_meas.sv ***
// low-pulse width measurement on the flush/wake pin
`timescale 1ns/1ps
module imsw_pulse_meas #(
	parameter int SHORT_CYC = 13,
	parameter int LONG_CYC  = 1_000_000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pin and gating
	input  wire logic pin_n,
	input  wire logic enable,
	// results
	output logic      fall,
	output logic      short_ok,
	output logic      long_ok
);
	localparam int CW = $clog2(LONG_CYC + 1);
	initial begin
		if (SHORT_CYC < 1 || LONG_CYC <= SHORT_CYC)
			$error("pulse limits out of range");
	end

	logic          prev_r, prev_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic          fall_r, fall_nxt;
	logic          sok_r, sok_nxt;
	logic          lok_r, lok_nxt;

	// count low time; report short once at release, long once at threshold
	always_comb begin
		prev_nxt = pin_n;
		cnt_nxt  = cnt_r;
		fall_nxt = enable && prev_r && !pin_n;
		sok_nxt  = 1'b0;
		lok_nxt  = 1'b0;
		if (!enable || pin_n) begin
			cnt_nxt = '0;
			if (enable && !prev_r && cnt_r >= CW'(SHORT_CYC - 1) && cnt_r < CW'(LONG_CYC))
				sok_nxt = 1'b1;
		end else if (cnt_r != CW'(LONG_CYC)) begin
			cnt_nxt = cnt_r + CW'(1);
			lok_nxt = (cnt_r == CW'(LONG_CYC - 1));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_r <= 1'b1;
			cnt_r  <= '0;
			fall_r <= 1'b0;
			sok_r  <= 1'b0;
			lok_r  <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
			cnt_r  <= cnt_nxt;
			fall_r <= fall_nxt;
			sok_r  <= sok_nxt;
			lok_r  <= lok_nxt;
		end
	end

	assign fall     = fall_r;
	assign short_ok = sok_r;
	assign long_ok  = lok_r;
endmodule

// *** imsw_top.sv ***
// interface mode select and flush/wake controller with AHB-Lite registers
//
// Functional notes
// RULE1 - flush/wake input acts only in FIFO or bit-bang modes.
// RULE2 - send-immediate returns buffered data as a short packet at once.
// RULE3 - falling edge of flush/wake flags a pending flush to the host.
// RULE4 - external logic holds flush/wake low 250 ns to request a flush.
// RULE5 - external logic holds flush/wake low 20 ms to wake the host.
// RULE6 - external logic flushes only after it stops writing data.
// RULE7 - with pull-down enabled, flush/wake never ends suspend.
// RULE8 - in serial mode ring-indicate is the wake input instead.
// RULE9 - without configuration the device runs asynchronous serial mode.
// RULE10 - after reset configuration memory is read and a base mode chosen.
// RULE11 - after enumeration host command selects bit-bang or serial engine.
// RULE12 - value 0x40 selects synchronous FIFO only from parallel FIFO base.
// RULE13 - drive strength, slew and Schmitt settings come from configuration.
// RULE14 - base modes only from configuration, bit-bang and engine from host.
// RULE15 - host may place fast serial controller into reset.
// RULE16 - value 0x10 holds fast serial in reset, 0x00 releases it.
// RULE17 - reset discards host-selected modes and reloads the configuration.
`timescale 1ns/1ps
module imsw_top #(
	parameter int WAKE_CYC = imsw_pkg::WAKE_CYC
) (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [7:0]  HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// configuration memory word
	input  wire logic [15:0] CFG_WORD,
	// pins
	input  wire logic        FLUSH_WAKE_N,
	input  wire logic        RING_INDICATE_N,
	// to the USB engine
	input  wire logic        FLUSH_ACK,
	output logic             FLUSH_PEND,
	output logic             SHORT_PKT,
	output logic             REMOTE_WAKE,
	output logic             FS_RESET,
	output logic [3:0]       ACTIVE_MODE,
	output logic             CFG_VALID,
	// pad settings
	output logic [1:0]       PAD_DRIVE,
	output logic             PAD_SLEW,
	output logic             PAD_SCHMITT
);
	initial begin
		if (WAKE_CYC <= imsw_pkg::FLUSH_CYC)
			$error("wake count must exceed flush count");
	end

	// ****************************************************************
	// configuration load
	// ****************************************************************
	imsw_cfg_if #(.W(imsw_pkg::CFG_W)) cfg ();
	assign cfg.req = 1'b1;

	imsw_cfg_loader #(.W(imsw_pkg::CFG_W)) u_ldr (
		.clk      (REF_CLK),
		.rst_n    (RSTN),
		.mem_word (CFG_WORD),
		.cfg      (cfg)
	);

	// decode the base mode, falling back to serial on an unknown code
	function automatic imsw_pkg::imsw_act_t base_to_act(input logic [2:0] code);
		unique case (code)
			3'd1:    base_to_act = imsw_pkg::IMSW_ACT_ASYNC_FIFO;
			3'd2:    base_to_act = imsw_pkg::IMSW_ACT_CPU_FIFO;
			3'd3:    base_to_act = imsw_pkg::IMSW_ACT_HDBUS;
			3'd4:    base_to_act = imsw_pkg::IMSW_ACT_FAST_SERIAL;
			default: base_to_act = imsw_pkg::IMSW_ACT_UART; // [RULE9]
		endcase
	endfunction

	logic [2:0] base_code;
	assign base_code = cfg.word[imsw_pkg::CFG_MODE_LSB +: 3];

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	logic        aph_wr_r, aph_wr_nxt;
	logic        aph_rd_r, aph_rd_nxt;
	logic [7:0]  aph_addr_r, aph_addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        take;
	// mode and control state, declared here because the read mux below uses it
	imsw_pkg::imsw_act_t mode_r, mode_nxt;
	logic [7:0]  cmd_val_r, cmd_val_nxt;
	logic [31:0] ctrl_r, ctrl_nxt;
	logic        fs_rst_r, fs_rst_nxt;
	logic        pend_r, pend_nxt;
	logic        wake_r, wake_nxt;
	logic        ld_seen_r, ld_seen_nxt;
	logic        enumerated, suspended, pulldn, is_fifo_bb, is_uart;
	logic        w_cmd;
	logic        pin_fall, pin_short, pin_long;
	logic        ri_prev_r, ri_prev_nxt;

	assign take = HSEL && HREADY && HTRANS[1];

	// single-cycle zero-wait-state slave; unmapped reads give zero
	always_comb begin
		aph_wr_nxt   = take && HWRITE;
		aph_rd_nxt   = take && !HWRITE;
		aph_addr_nxt = take ? HADDR : aph_addr_r;
		rdata_nxt    = rdata_r;
		if (aph_rd_nxt) begin
			unique case (HADDR)
				imsw_pkg::REG_CMD:    rdata_nxt = {24'h00_0000, cmd_val_r};
				imsw_pkg::REG_STATUS: rdata_nxt = {24'h00_0000, fs_rst_r, wake_r, pend_r,
					cfg.done, ACTIVE_MODE};
				imsw_pkg::REG_CFG:    rdata_nxt = {16'h0000, cfg.word};
				imsw_pkg::REG_CTRL:   rdata_nxt = ctrl_r;
				default:              rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// mode and control state
	// ****************************************************************
	assign enumerated = ctrl_r[0];
	assign suspended  = ctrl_r[1];
	assign pulldn     = cfg.word[imsw_pkg::CFG_PULLDN_BIT];
	assign is_uart    = (mode_r == imsw_pkg::IMSW_ACT_UART);
	assign w_cmd      = aph_wr_r && (aph_addr_r == imsw_pkg::REG_CMD);

	// flush/wake only in FIFO and bit-bang modes
	assign is_fifo_bb = (mode_r == imsw_pkg::IMSW_ACT_ASYNC_FIFO)
		|| (mode_r == imsw_pkg::IMSW_ACT_SYNC_FIFO)
		|| (mode_r == imsw_pkg::IMSW_ACT_CPU_FIFO)
		|| (mode_r == imsw_pkg::IMSW_ACT_ASYNC_BB)
		|| (mode_r == imsw_pkg::IMSW_ACT_SYNC_BB); // [RULE1]

	imsw_pulse_meas #(
		.SHORT_CYC (imsw_pkg::FLUSH_CYC),
		.LONG_CYC  (WAKE_CYC)
	) u_meas (
		.clk      (REF_CLK),
		.rst_n    (RSTN),
		.pin_n    (FLUSH_WAKE_N),
		.enable   (is_fifo_bb && cfg.done),
		.fall     (pin_fall),
		.short_ok (pin_short),
		.long_ok  (pin_long)
	);

	// mode selection, command handling, flush and wake flags
	always_comb begin
		mode_nxt    = mode_r;
		cmd_val_nxt = cmd_val_r;
		ctrl_nxt    = ctrl_r;
		fs_rst_nxt  = fs_rst_r;
		pend_nxt    = pend_r;
		wake_nxt    = 1'b0;
		ld_seen_nxt = ld_seen_r || cfg.done;
		ri_prev_nxt = RING_INDICATE_N;
		// base mode taken once the configuration word arrives
		if (cfg.done && !ld_seen_r)
			mode_nxt = base_to_act(base_code); // [RULE10] [RULE14]
		if (aph_wr_r && aph_addr_r == imsw_pkg::REG_CTRL)
			ctrl_nxt = {30'h0000_0000, HWDATA[1:0]};
		// host commands act only after load and enumeration
		if (w_cmd && ld_seen_r && enumerated) begin // [RULE11]
			cmd_val_nxt = HWDATA[7:0];
			unique case (HWDATA[7:0])
				imsw_pkg::BM_ASYNC_BB:   mode_nxt = imsw_pkg::IMSW_ACT_ASYNC_BB; // [RULE14]
				imsw_pkg::BM_SYNC_BB:    mode_nxt = imsw_pkg::IMSW_ACT_SYNC_BB;
				imsw_pkg::BM_SERIAL_ENG: mode_nxt = imsw_pkg::IMSW_ACT_SERIAL_ENGINE;
				imsw_pkg::BM_SYNC_FIFO: begin
					if (base_code == 3'd1)
						mode_nxt = imsw_pkg::IMSW_ACT_SYNC_FIFO; // [RULE12]
				end
				imsw_pkg::BM_FS_HOLD: begin
					if (mode_r == imsw_pkg::IMSW_ACT_FAST_SERIAL)
						fs_rst_nxt = 1'b1; // [RULE15] [RULE16]
				end
				imsw_pkg::BM_RESET: begin
					fs_rst_nxt = 1'b0; // [RULE16]
					mode_nxt   = base_to_act(base_code);
				end
				default: ;
			endcase
		end
		// flush: clear by engine ack, but a new edge wins
		if (FLUSH_ACK)
			pend_nxt = 1'b0;
		if (pin_fall)
			pend_nxt = 1'b1; // [RULE3] [RULE2]
		// wake: long pulse unless pull-down, or ring indicate in serial mode
		if (suspended && !pulldn && pin_long)
			wake_nxt = 1'b1; // [RULE7] [RULE5]
		if (suspended && is_uart && ri_prev_r && !RING_INDICATE_N)
			wake_nxt = 1'b1; // [RULE8]
	end

	// all host-chosen state is dropped on reset
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			mode_r     <= imsw_pkg::IMSW_ACT_UART; // [RULE17] [RULE9]
			cmd_val_r  <= 8'h00;
			ctrl_r     <= imsw_pkg::CTRL_RST;
			fs_rst_r   <= 1'b0;
			pend_r     <= 1'b0;
			wake_r     <= 1'b0;
			ld_seen_r  <= 1'b0;
			ri_prev_r  <= 1'b1;
			aph_wr_r   <= 1'b0;
			aph_rd_r   <= 1'b0;
			aph_addr_r <= 8'h00;
			rdata_r    <= 32'h0000_0000;
		end else begin
			mode_r     <= mode_nxt;
			cmd_val_r  <= cmd_val_nxt;
			ctrl_r     <= ctrl_nxt;
			fs_rst_r   <= fs_rst_nxt;
			pend_r     <= pend_nxt;
			wake_r     <= wake_nxt;
			ld_seen_r  <= ld_seen_nxt;
			ri_prev_r  <= ri_prev_nxt;
			aph_wr_r   <= aph_wr_nxt;
			aph_rd_r   <= aph_rd_nxt;
			aph_addr_r <= aph_addr_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign HRDATA      = rdata_r;
	assign HREADYOUT   = 1'b1;
	assign HRESP       = 1'b0;
	assign FLUSH_PEND  = pend_r;
	assign SHORT_PKT   = pin_short; // released short pulse marks the short packet [RULE2]
	assign REMOTE_WAKE = wake_r;
	assign FS_RESET    = fs_rst_r;
	assign ACTIVE_MODE = mode_r;
	assign CFG_VALID   = ld_seen_r;
	// pad settings straight from the loaded word [RULE13]
	assign PAD_DRIVE   = cfg.word[imsw_pkg::CFG_DRIVE_LSB +: 2];
	assign PAD_SLEW    = cfg.word[imsw_pkg::CFG_SLEW_BIT];
	assign PAD_SCHMITT = cfg.word[imsw_pkg::CFG_SCHMITT_BIT];
endmodule

// *** imsw_checker.sv ***
// checker of the mode select and flush/wake controller ports
`timescale 1ns/1ps
module imsw_checker #(
	parameter int WAKE_CYC = 50
) (
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        RSTN,
	// watched signals
	input wire logic [15:0] CFG_WORD,
	input wire logic        FLUSH_WAKE_N,
	input wire logic        FLUSH_ACK,
	input wire logic        FLUSH_PEND,
	input wire logic        SHORT_PKT,
	input wire logic        REMOTE_WAKE,
	input wire logic        FS_RESET,
	input wire logic [3:0]  ACTIVE_MODE,
	input wire logic        CFG_VALID,
	input wire logic [1:0]  PAD_DRIVE,
	input wire logic        PAD_SLEW,
	input wire logic        PAD_SCHMITT
);
	// ****************************************************************
	// helper logic
	// ****************************************************************
	logic       en;
	logic [7:0] low_r;
	logic [7:0] low_nxt;
	// pin is live only in fifo and bit-bang modes
	assign en = CFG_VALID && (ACTIVE_MODE inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7});
	// low samples in a row, saturating so a wake pulse cannot wrap to a short one
	always_comb begin
		low_nxt = FLUSH_WAKE_N ? 8'h00 : ((low_r == 8'hFF) ? low_r : low_r + 8'h01);
	end
	always_ff @(posedge REF_CLK) begin
		low_r <= !RSTN ? 8'h00 : low_nxt;
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// ****************************************************************
	// assertions
	// ****************************************************************
	AST_MODE_AT_RELEASE: assert property ($rose(RSTN) |-> ACTIVE_MODE == 4'h0 && !CFG_VALID)
		else $error("mode not cleared by reset");
	AST_LOAD_TIME: assert property ($rose(RSTN) |-> ##[3:7] CFG_VALID)
		else $error("configuration not loaded in time");
	AST_PAD_FROM_CFG: assert property ($rose(CFG_VALID) |-> PAD_DRIVE == CFG_WORD[5:4]
		&& PAD_SLEW == CFG_WORD[6] && PAD_SCHMITT == CFG_WORD[7])
		else $error("pad settings differ from configuration");
	AST_PEND_SET: assert property ($fell(FLUSH_WAKE_N) && en |-> ##[1:3] FLUSH_PEND)
		else $error("falling pin did not flag a flush");
	AST_PEND_GATED: assert property ($rose(FLUSH_PEND) |-> $past(en, 2))
		else $error("flush flagged in a mode without the pin");
	AST_PEND_STANDS: assert property (FLUSH_PEND && !FLUSH_ACK |=> FLUSH_PEND)
		else $error("pending flush dropped without acknowledge");
	AST_SHORT_AFTER: assert property ($rose(FLUSH_WAKE_N) && en && low_r >= 8'd15
		&& low_r < WAKE_CYC - 5 |-> ##[1:3] SHORT_PKT)
		else $error("short packet missing after flush pulse");
	AST_NO_SHORT_GLITCH: assert property ($rose(FLUSH_WAKE_N) && low_r < 8'd8 |-> !SHORT_PKT [*4])
		else $error("short packet after a glitch");
	AST_SHORT_ONE: assert property (SHORT_PKT |=> !SHORT_PKT)
		else $error("short packet longer than one cycle");
	AST_FS_ONLY_FAST: assert property (FS_RESET |-> ACTIVE_MODE == 4'h5)
		else $error("fast serial reset outside fast serial mode");
	AST_WAKE_PULLDOWN: assert property (REMOTE_WAKE && ACTIVE_MODE != 4'h0 |-> !CFG_WORD[8])
		else $error("wake with pull-down enabled");
endmodule

// *** imsw_partner.sv ***
// model of the peripheral logic on the pin and of the usb engine acknowledge
`timescale 1ns/1ps
module imsw_partner (
	// clock and commands
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic [31:0] len,
	input  wire logic        ack_en,
	// device side
	input  wire logic        pend,
	output logic             pin_n,
	output logic             ack
);
	initial begin
		pin_n = 1'b1;
		ack = 1'b0;
	end
	// low pulse of the commanded width; the pin idles high on its pull-up
	always @(posedge clk) begin
		if (go) begin
			pin_n <= 1'b0;
			repeat (len) @(posedge clk);
			pin_n <= 1'b1;
		end
	end
	// engine takes the flush some cycles later, prompt or slow at random
	always @(posedge clk) begin
		if (pend && ack_en && !ack) begin
			repeat ($urandom_range(6, 1)) @(posedge clk);
			ack <= 1'b1;
			@(posedge clk);
			ack <= 1'b0;
		end
	end
endmodule

// *** test_interface_mode_select_and_flush_wake.sv ***
// self-checking bench of the mode select and flush/wake controller
`timescale 1ns/1ps
`define CK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_interface_mode_select_and_flush_wake;
	localparam int WK = 50;
	logic        clk, rstn, hsel, hwrite, go, ack_en, rd_ph, ring_n;
	logic [1:0]  htrans;
	logic [7:0]  haddr;
	logic [31:0] hwdata, plen, e;
	logic [15:0] cfg_w;
	logic [3:0]  m;
	logic        p;
	wire logic   hready, pin_n, ack, pend, short_pkt, wake;
	wire [31:0]  hrdata;
	logic [31:0] exp_q[$];
	int          bad_count, n_checks, n_short, n_wake, c;
	logic [7:0] c_tab [3] = '{imsw_pkg::BM_ASYNC_BB, imsw_pkg::BM_SERIAL_ENG, imsw_pkg::BM_SYNC_BB};
	logic [3:0] m_tab [3] = '{4'h6, 4'h8, 4'h7};
	logic [3:0] b_tab [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5};
	// ****************************************************************
	// clock, design and far side
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	imsw_top #(.WAKE_CYC(WK)) u_imsw_top (.REF_CLK(clk), .RSTN(rstn), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .CFG_WORD(cfg_w),
		.FLUSH_WAKE_N(pin_n), .RING_INDICATE_N(ring_n), .FLUSH_ACK(ack), .FLUSH_PEND(pend),
		.SHORT_PKT(short_pkt), .REMOTE_WAKE(wake), .FS_RESET(), .ACTIVE_MODE(),
		.CFG_VALID(), .PAD_DRIVE(), .PAD_SLEW(), .PAD_SCHMITT());
	imsw_partner u_imsw_partner (.clk(clk), .go(go), .len(plen), .ack_en(ack_en),
		.pend(pend), .pin_n(pin_n), .ack(ack));
	// monitor: read data against the oldest note, pulses counted
	always @(posedge clk) begin
		if (rd_ph && hready) begin
			e = exp_q.pop_front();
			`CK(hrdata, e)
		end
		if (short_pkt === 1'b1) n_short++;
		if (wake === 1'b1) n_wake++;
	end
	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; rd_ph <= !w;
		if (!w) exp_q.push_back(d);
		do @(posedge clk); while (hready !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task automatic do_reset(input logic [15:0] w);
		@(posedge clk);
		rstn <= 1'b0; cfg_w <= w;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	// flush only while no data is written, the bench has no data path
	task automatic pulse(input int n);
		@(posedge clk);
		plen <= n; go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (n + 8) @(posedge clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard, far above the roughly nine hundred cycles the tests take
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		{hsel, hwrite, go, ack_en, rd_ph, htrans, haddr, hwdata, plen} = '0;
		rstn = 1'b0; ring_n = 1'b1; cfg_w = 16'h0000;
		void'($urandom(66));
		do_reset({8'h00, 4'($urandom()), 4'h0});
		ahb(0, imsw_pkg::REG_CFG, {16'h0000, cfg_w});
		ahb(0, imsw_pkg::REG_STATUS, 32'h0000_0010);
		ahb(1, imsw_pkg::REG_CMD, {24'h0, imsw_pkg::BM_ASYNC_BB});
		ahb(0, imsw_pkg::REG_STATUS, 32'h0000_0010);
		ahb(1, imsw_pkg::REG_CTRL, 32'h0000_0001);
		foreach (c_tab[i]) begin
			ahb(1, imsw_pkg::REG_CMD, {24'h0, c_tab[i]});
			ahb(0, imsw_pkg::REG_STATUS, {28'h0000_001, m_tab[i]});
			ahb(1, imsw_pkg::REG_CMD, {24'h0, imsw_pkg::BM_RESET});
		end
		ahb(0, 8'h10, 32'h0000_0000);
		$display("test defaults and host modes done");
		ahb(1, imsw_pkg::REG_CTRL, 32'h0000_0003);
		ring_n <= 1'b0;
		repeat (WK + 10) @(posedge clk);
		ring_n <= 1'b1;
		repeat (10) @(posedge clk);
		`CK(n_wake != 0, 1'b1)
		c = n_wake;
		pulse(WK + 10);
		`CK(n_wake, c)
		`CK(pend, 1'b0)
		$display("test serial wake done");
		for (int b = 0; b < 5; b++) begin
			do_reset(16'(b));
			m = (b == 1) ? 4'h2 : b_tab[b];
			p = m inside {4'h1, 4'h2, 4'h3};
			c = n_short;
			ahb(1, imsw_pkg::REG_CTRL, 32'h0000_0001);
			ahb(1, imsw_pkg::REG_CMD, {24'h0, imsw_pkg::BM_SYNC_FIFO});
			pulse(20);
			ahb(0, imsw_pkg::REG_STATUS, {26'h0, p, 1'b1, m});
			`CK(n_short, c + int'(p))
		end
		ahb(1, imsw_pkg::REG_CMD, {24'h0, imsw_pkg::BM_FS_HOLD});
		ahb(0, imsw_pkg::REG_STATUS, 32'h0000_0095);
		ahb(0, imsw_pkg::REG_CMD, 32'h0000_0010);
		ahb(1, imsw_pkg::REG_CMD, {24'h0, imsw_pkg::BM_RESET});
		ahb(0, imsw_pkg::REG_STATUS, 32'h0000_0015);
		$display("test base modes done");
		do_reset(16'h0001);
		ahb(1, imsw_pkg::REG_CTRL, 32'h0000_0001);
		ahb(1, imsw_pkg::REG_CMD, {24'h0, imsw_pkg::BM_SERIAL_ENG});
		ahb(0, imsw_pkg::REG_STATUS, 32'h0000_0018);
		do_reset(16'h0001);
		ahb(0, imsw_pkg::REG_STATUS, 32'h0000_0011);
		ack_en <= 1'b1;
		c = n_short;
		pulse($urandom_range(40, 16));
		`CK(n_short, c + 1)
		`CK(pend, 1'b0)
		pulse(5);
		`CK(n_short, c + 1)
		ahb(1, imsw_pkg::REG_CTRL, 32'h0000_0003);
		c = n_wake;
		pulse(WK + 10);
		`CK(n_wake, c + 1)
		do_reset(16'h0101);
		ahb(1, imsw_pkg::REG_CTRL, 32'h0000_0003);
		pulse(WK + 10);
		`CK(n_wake, c + 1)
		$display("test flush and wake done");
		print_verdict();
	end
endmodule
bind imsw_top imsw_checker #(.WAKE_CYC(WAKE_CYC)) u_imsw_checker (.REF_CLK(REF_CLK),
	.RSTN(RSTN), .CFG_WORD(CFG_WORD), .FLUSH_WAKE_N(FLUSH_WAKE_N), .FLUSH_ACK(FLUSH_ACK),
	.FLUSH_PEND(FLUSH_PEND), .SHORT_PKT(SHORT_PKT), .REMOTE_WAKE(REMOTE_WAKE),
	.FS_RESET(FS_RESET), .ACTIVE_MODE(ACTIVE_MODE), .CFG_VALID(CFG_VALID),
	.PAD_DRIVE(PAD_DRIVE), .PAD_SLEW(PAD_SLEW), .PAD_SCHMITT(PAD_SCHMITT));
